// File: logic/gpio_defs.svh
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
// Contract
// - Input line reads live pad level
// - Output line driven by written value
// - Alternate line follows internal function logic
// - All lines input after reset
// - Lines 1-4 audio, 6 alarm, 7 status
// - Outputs drive push-pull both levels
// - Status indicator only on line seven
// - Pad inverted; off, on states fixed
// - Idle or dial-up: 1s on, 2s off
// - Power saving: lamp follows wake events
// - Any line selectable as SIM detect
`define GPIO_NUM_LINES     7
`define REG_DIR            12'h000
`define REG_OUT            12'h004
`define REG_IN             12'h008
`define REG_ALT            12'h00c
`define REG_STATUS_CFG     12'h010
`define REG_SIMDET         12'h014
`define REG_SIMDET_STATUS  12'h018
`define RST_DIR            7'h00
`define RST_OUT            7'h00
`define RST_ALT            7'h00
`define SIMDET_MODE_ON     2'h2
`define SIMDET_MODE_LSB    0
`define SIMDET_PIN_LSB     4
`define STAT_STATE_LSB     0
`define STAT_WAKE_LSB      4
`define CLK_HZ             200000000
`define LED_ON_MS          1000
`define LED_OFF_MS         2000
`define LED_TICK_MS        1
`define LED_TICK_CYCLES    ((`CLK_HZ / 1000) * `LED_TICK_MS)
`endif

// File: logic/gpio_pkg.sv
package gpio_pkg;
  typedef enum logic [2:0] {
    DEV_OFF        = 3'b000,
    DEV_UNREG      = 3'b001,
    DEV_REG_IDLE   = 3'b010,
    DEV_REG_SAVING = 3'b011,
    DEV_VOICE_CALL = 3'b100,
    DEV_DIAL_UP    = 3'b101
  } dev_state_t;
  typedef struct packed {
    logic [6:0] o;
    logic [6:0] oe;
  } pad_drive_t;
  typedef struct packed {
    logic frame;
    logic tx;
    logic clk;
    logic frame_oe;
    logic tx_oe;
    logic clk_oe;
    logic alarm;
  } alt_drive_t;
endpackage : gpio_pkg

// File: logic/status_blinker.sv
`timescale 1ns/10ps
`include "gpio_defs.svh"
module status_blinker #(
  parameter int unsigned TICK_CYCLES = `LED_TICK_CYCLES,
  parameter int unsigned ON_TICKS    = `LED_ON_MS / `LED_TICK_MS,
  parameter int unsigned OFF_TICKS   = `LED_OFF_MS / `LED_TICK_MS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire gpio_pkg::dev_state_t  dev_state,
  input  wire logic                  wake_event,
  output logic                       lamp_on
);
  import gpio_pkg::*;
  // Counters are 24 and 16 bits wide
  if (TICK_CYCLES < 1 || ON_TICKS < 1 || OFF_TICKS < 1 || TICK_CYCLES > 32'h1000000 ||
      ON_TICKS + OFF_TICKS > 32'h10000) begin : g_bad_timing
    $error("status_blinker: bad timing parameters");
  end
  logic [23:0] div_cnt;
  logic        tick;
  logic [15:0] phase;
  dev_state_t  last_state;
  // Millisecond enable pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 24'h000000;
    end else if (div_cnt == 24'(TICK_CYCLES - 1)) begin
      div_cnt <= 24'h000000;
    end else begin
      div_cnt <= div_cnt + 24'h000001;
    end
  end
  assign tick = (div_cnt == 24'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_state <= DEV_OFF;
    end else begin
      last_state <= dev_state;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 16'h0000;
    end else if (last_state != dev_state) begin
      phase <= 16'h0000;
    end else if (tick) begin
      if (phase == 16'(ON_TICKS + OFF_TICKS - 1)) begin
        phase <= 16'h0000;
      end else begin
        phase <= phase + 16'h0001;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_on <= 1'b0;
    end else begin
      case (dev_state)
        DEV_OFF:        lamp_on <= 1'b0;
        DEV_UNREG:      lamp_on <= 1'b1;
        DEV_VOICE_CALL: lamp_on <= 1'b1;
        DEV_REG_IDLE:   lamp_on <= (phase < 16'(ON_TICKS));
        DEV_DIAL_UP:    lamp_on <= (phase < 16'(ON_TICKS));
        DEV_REG_SAVING: lamp_on <= wake_event;
        default:        lamp_on <= 1'b0;
      endcase
    end
  end
endmodule : status_blinker

// File: logic/gpio_port.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "gpio_defs.svh"
module gpio_port #(
  parameter int unsigned NUM_LINES   = `GPIO_NUM_LINES,
  parameter int unsigned TICK_CYCLES = `LED_TICK_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [6:0]            pad_i,
  output gpio_pkg::pad_drive_t       pad_drive,
  input  wire gpio_pkg::alt_drive_t  alt_drive,
  output logic                       audio_rx,
  input  wire logic                  power_wake,
  output logic                       sim_presence_detect
);
  import gpio_pkg::*;
  if (NUM_LINES != 7) begin : g_bad_lines
    $error("gpio_port: only seven lines are supported");
  end
  logic [6:0] dir;
  logic [6:0] out_val;
  logic [6:0] alt_en;
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [2:0] stat_cfg;
  logic       stat_wake;
  logic [1:0] simdet_mode;
  logic [2:0] simdet_pin;
  logic       lamp_on;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [31:0] next_prdata;
  dev_state_t dev_state;
  pad_drive_t next_drive;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign dev_state = dev_state_t'(stat_cfg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= pad_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir     <= `RST_DIR;
      out_val <= `RST_OUT;
      alt_en  <= `RST_ALT;
    end else if (wr_en) begin
      if (paddr == `REG_DIR) begin
        dir <= pwdata[6:0];
      end else if (paddr == `REG_OUT) begin
        out_val <= pwdata[6:0];
      end else if (paddr == `REG_ALT) begin
        alt_en <= pwdata[6:0] & 7'h6f;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_cfg  <= 3'h0;
      stat_wake <= 1'b0;
    end else begin
      if (wr_en && paddr == `REG_STATUS_CFG) begin
        stat_cfg  <= pwdata[`STAT_STATE_LSB +: 3];
        stat_wake <= pwdata[`STAT_WAKE_LSB];
      end else begin
        stat_wake <= power_wake;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simdet_mode <= 2'h0;
      simdet_pin  <= 3'h0;
    end else if (wr_en && paddr == `REG_SIMDET) begin
      simdet_mode <= pwdata[`SIMDET_MODE_LSB +: 2];
      if (pwdata[`SIMDET_PIN_LSB +: 3] < 3'h7) begin
        simdet_pin <= pwdata[`SIMDET_PIN_LSB +: 3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sim_presence_detect <= 1'b0;
    end else begin
      sim_presence_detect <= (simdet_mode == `SIMDET_MODE_ON) && sync2[simdet_pin];
    end
  end

  status_blinker #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_blinker (
    .pclk       (pclk),
    .presetn    (presetn),
    .dev_state  (dev_state),
    .wake_event (stat_wake),
    .lamp_on    (lamp_on)
  );

  // Pad drive mux
  always_comb begin
    next_drive.o  = 7'h00;
    next_drive.oe = 7'h00;
    for (int i = 0; i < 7; i++) begin
      next_drive.o[i]  = out_val[i];
      next_drive.oe[i] = dir[i];
    end
    if (alt_en[0]) begin
      next_drive.o[0]  = alt_drive.frame;
      next_drive.oe[0] = alt_drive.frame_oe;
    end
    if (alt_en[1]) begin
      next_drive.o[1]  = 1'b0;
      next_drive.oe[1] = 1'b0;
    end
    if (alt_en[2]) begin
      next_drive.o[2]  = alt_drive.tx;
      next_drive.oe[2] = alt_drive.tx_oe;
    end
    if (alt_en[3]) begin
      next_drive.o[3]  = alt_drive.clk;
      next_drive.oe[3] = alt_drive.clk_oe;
    end
    if (alt_en[5]) begin
      next_drive.o[5]  = alt_drive.alarm;
      next_drive.oe[5] = 1'b1;
    end
    if (alt_en[6]) begin
      next_drive.o[6]  = ~lamp_on;
      next_drive.oe[6] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_drive <= '0;
      audio_rx  <= 1'b0;
    end else begin
      pad_drive <= next_drive;
      audio_rx  <= alt_en[1] & sync2[1];
    end
  end

  // Register read decode
  always_comb begin
    addr_ok     = 1'b1;
    next_prdata = 32'h00000000;
    if (paddr == `REG_DIR) begin
      next_prdata[6:0] = dir;
    end else if (paddr == `REG_OUT) begin
      next_prdata[6:0] = out_val;
    end else if (paddr == `REG_IN) begin
      next_prdata[6:0] = sync2;
    end else if (paddr == `REG_ALT) begin
      next_prdata[6:0] = alt_en;
    end else if (paddr == `REG_STATUS_CFG) begin
      next_prdata[`STAT_STATE_LSB +: 3] = stat_cfg;
      next_prdata[`STAT_WAKE_LSB]       = stat_wake;
    end else if (paddr == `REG_SIMDET) begin
      next_prdata[`SIMDET_MODE_LSB +: 2] = simdet_mode;
      next_prdata[`SIMDET_PIN_LSB +: 3]  = simdet_pin;
    end else if (paddr == `REG_SIMDET_STATUS) begin
      next_prdata[0] = sim_presence_detect;
      next_prdata[1] = lamp_on;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Assertions
  // Idle pads after reset
  a_reset_inputs: assert property (@(posedge pclk)
    $rose(presetn) |-> pad_drive.oe == 7'h00)
    else $error("pads driven after reset");
  a_out_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (dir[4] && !alt_en[4]) |=> pad_drive.o[4] == $past(out_val[4]))
    else $error("line five output mismatch");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |-> ##2 sync2 == $past(pad_i, 2))
    else $error("synchroniser latency wrong");
  a_stat_invert: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[6] |=> pad_drive.o[6] == !$past(lamp_on) && pad_drive.oe[6])
    else $error("status pad not inverted");
  a_line5_noalt: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[4] == 1'b0)
    else $error("line five alternate set");
  a_sim_mode: assert property (@(posedge pclk) disable iff (!presetn)
    sim_presence_detect |-> $past(simdet_mode) == `SIMDET_MODE_ON)
    else $error("detect without mode two");
  a_alarm_alt: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[5] |=> pad_drive.oe[5] && pad_drive.o[5] == $past(alt_drive.alarm))
    else $error("alarm not on line six");
  a_unreg_on: assert property (@(posedge pclk) disable iff (!presetn)
    (dev_state == DEV_UNREG) [*2] |-> lamp_on)
    else $error("lamp off while unregistered");
  c_stat_blink: cover property (@(posedge pclk) disable iff (!presetn)
    alt_en[6] && $fell(pad_drive.o[6]));
  c_sim_detect: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(sim_presence_detect));
  c_out_drive: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(pad_drive.oe[4]));
  c_wake_lamp: cover property (@(posedge pclk) disable iff (!presetn)
    dev_state == DEV_REG_SAVING && $rose(lamp_on));
  c_dial_blink: cover property (@(posedge pclk) disable iff (!presetn)
    dev_state == DEV_DIAL_UP && $fell(lamp_on));
  a_plain_drive: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (pad_drive.oe & ~$past(alt_en)) == ($past(dir) & ~$past(alt_en)) &&
      (pad_drive.o & ~$past(alt_en)) == ($past(out_val) & ~$past(alt_en)))
    else $error("plain line drive mismatch");
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `REG_DIR) |=> dir == $past(pwdata[6:0]))
    else $error("direction write lost");
  a_out_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `REG_OUT) |=> out_val == $past(pwdata[6:0]))
    else $error("output write lost");
  a_alt_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `REG_ALT) |=> alt_en == ($past(pwdata[6:0]) & 7'h6f))
    else $error("alternate write mask wrong");
  a_rx_input: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[1] |=> !pad_drive.oe[1])
    else $error("receive line driven");
  a_rx_sample: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> audio_rx == ($past(alt_en[1]) && $past(sync2[1])))
    else $error("receive data mismatch");
  a_frame_alt: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[0] |=> pad_drive.o[0] == $past(alt_drive.frame) &&
      pad_drive.oe[0] == $past(alt_drive.frame_oe))
    else $error("frame line mismatch");
  a_tx_alt: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[2] |=> pad_drive.o[2] == $past(alt_drive.tx) &&
      pad_drive.oe[2] == $past(alt_drive.tx_oe))
    else $error("transmit line mismatch");
  a_clk_alt: assert property (@(posedge pclk) disable iff (!presetn)
    alt_en[3] |=> pad_drive.o[3] == $past(alt_drive.clk) &&
      pad_drive.oe[3] == $past(alt_drive.clk_oe))
    else $error("bit clock line mismatch");
  a_stat_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !alt_en[6] |=> pad_drive.o[6] == $past(out_val[6]) &&
      pad_drive.oe[6] == $past(dir[6]))
    else $error("indicator without alternate");
  a_off_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (dev_state == DEV_OFF) [*2] |-> !lamp_on)
    else $error("lamp on while off");
  a_voice_on: assert property (@(posedge pclk) disable iff (!presetn)
    (dev_state == DEV_VOICE_CALL) [*2] |-> lamp_on)
    else $error("lamp off in voice call");
  a_wake_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (dev_state == DEV_REG_SAVING) |=> lamp_on == $past(stat_wake))
    else $error("lamp not following wake");
  a_sim_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (simdet_mode == `SIMDET_MODE_ON) |=>
      sim_presence_detect == |($past(sync2) & (7'h01 << $past(simdet_pin))))
    else $error("detect not following line");
  a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en |-> prdata == $past(next_prdata))
    else $error("read data not from setup");
  a_in_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `REG_IN) |=> prdata[6:0] == $past(sync2))
    else $error("input read mismatch");
  // Offsets past the last register refused
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr > `REG_SIMDET_STATUS) |-> pslverr)
    else $error("unmapped access not refused");
endmodule : gpio_port

// File: bench/pad_partner.sv
`timescale 1ns/10ps
module pad_partner (
  input  wire gpio_pkg::pad_drive_t  pad_drive,
  input  wire logic [6:0]            ext_level,
  output logic [6:0]                 pad_i,
  output logic                       lamp
);
  import gpio_pkg::*;
  assign pad_i = (pad_drive.oe & pad_drive.o) | (~pad_drive.oe & ext_level);
  assign lamp = ~pad_i[6];
endmodule : pad_partner

// File: bench/module_gpio_with_status_indicator_tb.sv
`timescale 1ns/10ps
`include "gpio_defs.svh"
module module_gpio_with_status_indicator_tb;
  import gpio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        power_wake, audio_rx, sim_presence_detect, lamp, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  pad_i, ext_level, dir, outv, m;
  pad_drive_t  pad_drive;
  alt_drive_t  alt_drive;
  int          miscompares, n_tests, seed, i, v;
  gpio_port #(.TICK_CYCLES(4)) gpio_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_i(pad_i), .pad_drive(pad_drive),
    .alt_drive(alt_drive), .audio_rx(audio_rx), .power_wake(power_wake),
    .sim_presence_detect(sim_presence_detect));
  pad_partner pad_partner_inst (.pad_drive(pad_drive), .ext_level(ext_level), .pad_i(pad_i),
    .lamp(lamp));
  always #2.5 pclk = ~pclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      test_done();
    end
  endtask : apb
  function automatic logic [6:0] exp_pad(input logic [6:0] d, o, e);
    return (d & o) | (~d & e);
  endfunction : exp_pad
  task lamp_at(input logic [2:0] st, input int wait_c, input logic exp);
    apb(1'b1, `REG_STATUS_CFG, {29'h0, st});
    repeat (wait_c) @(posedge pclk);
    chk(lamp, exp);
  endtask : lamp_at
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    ext_level = '0; alt_drive = '0; power_wake = 0; miscompares = 0; n_tests = 0;
    seed = 32'hd39765b6;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pad_drive.oe, 0);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 12'h000 + 12'(i * 4) + (i == 3 ? 12'h004 : 12'h000), 0);
      chk(rd, 0);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    for (i = 0; i < 24; i++) begin
      dir = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
      outv = 7'($random(seed));
      ext_level <= 7'($random(seed));
      apb(1'b1, `REG_DIR, {25'h0, dir});
      apb(1'b1, `REG_OUT, {25'h0, outv});
      repeat (3) @(posedge pclk);
      chk(pad_drive.oe, dir);
      chk(pad_drive.o & dir, outv & dir);
      apb(1'b0, `REG_IN, 0);
      chk(rd[6:0], exp_pad(dir, outv, ext_level));
    end
    // detect on each of the seven lines, all kept as plain inputs
    apb(1'b1, `REG_DIR, 0);
    for (i = 0; i < 7; i++) begin
      apb(1'b1, `REG_SIMDET, 32'(i << 4) | 32'h2);
      for (v = 0; v < 2; v++) begin
        ext_level <= v[0] ? (7'h1 << i) : ~(7'h1 << i);
        repeat (4) @(posedge pclk);
        chk(sim_presence_detect, v[0]);
        apb(1'b0, `REG_SIMDET_STATUS, 0);
        chk(rd[0], v[0]);
      end
    end
    apb(1'b1, `REG_SIMDET, 32'h61);
    repeat (4) @(posedge pclk);
    chk(sim_presence_detect, 0);
    alt_drive <= 7'($random(seed));
    ext_level <= 7'h02;
    apb(1'b1, `REG_ALT, 32'h7f);
    apb(1'b0, `REG_ALT, 0);
    chk(rd[6:0], 7'h6f);
    repeat (3) @(posedge pclk);
    m = {2'b11, 1'b0, alt_drive.clk_oe, alt_drive.tx_oe, 1'b0, alt_drive.frame_oe};
    chk(pad_drive.oe, m);
    chk(pad_drive.o & m[5:0], {1'b0, alt_drive.alarm, 1'b0, alt_drive.clk, alt_drive.tx,
      1'b0, alt_drive.frame} & m[5:0]);
    chk(audio_rx, 1'b1);
    ext_level <= 7'h00;
    repeat (4) @(posedge pclk);
    chk(audio_rx, 1'b0);
    chk(lamp, 1'b0);
    lamp_at(3'd1, 20, 1'b1);
    lamp_at(3'd4, 20, 1'b1);
    lamp_at(3'd0, 20, 1'b0);
    for (v = 0; v < 2; v++) begin
      // one tick of 4 cycles per ms
      lamp_at(v[0] ? 3'd5 : 3'd2, 2000, 1'b1);
      repeat (4000) @(posedge pclk);
      chk(lamp, 1'b0);
      repeat (6500) @(posedge pclk);
      chk(lamp, 1'b1);
    end
    apb(1'b1, `REG_STATUS_CFG, 32'h3);
    for (v = 0; v < 4; v++) begin
      power_wake <= v[0];
      repeat (10) @(posedge pclk);
      chk(lamp, v[0]);
    end
    ext_level <= 7'h55;
    presetn   <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pad_drive.oe, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pad_drive.oe, 0);
    apb(1'b0, `REG_ALT, 0);
    chk(rd[6:0], 7'h00);
    apb(1'b0, `REG_IN, 0);
    chk(rd[6:0], 7'h55);
    test_done();
  end
endmodule : module_gpio_with_status_indicator_tb
